// *** rtl/iovfr_fault_response.sv ***
// Input over-voltage fault limit, response setting and the response engine.
// Assumes a command port fed by the bus front end and same-clock measurements.
// Functional notes
// RL1: Threshold word, read and write, command code 0x55, Linear volts.
// RL2: Response byte, read and write, command 0x56, bits 7:6 pick action.
// RL3: Action 00 ignores the fault; output keeps running.
// RL4: Action 01 runs on for the delay, then retries if fault persists.
// RL5: Action 10 disables output at once, then follows retry setting.
// RL6: Action 11 keeps output off until the fault is cleared.
// RL7: Retry setting 000 never restarts; output stays off until cleared.
// RL8: Retry setting 001 tries once, then stays off until cleared.
// RL9: Retry setting 010 tries twice, then stays off until cleared.
// RL10: Retry setting 011 tries three times, then stays off until cleared.
// RL11: Restart attempts start one programmed delay apart.
// RL12: Delay field sets both run-on time and restart spacing.
// RL13: Delay field 1 to 7 means two to that power in units.
// RL14: Unit length comes from the separate time-unit configuration.
// RL15: Delay field 0 means one time unit.
// RL16: Retry settings 100 to 110 try four to six times.
// RL17: Retry setting 111 retries endlessly until commanded off.
// RL18: Fault when input exceeds threshold; sticky status flag for host.
// RL19: Host uses word access for threshold and byte access for response.
`default_nettype none
`include "iovfr_defines.svh"
module iovfr_fault_response #(
    parameter int UNIT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire iovfr_pkg::iovfr_cmd_s cmd,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic cmdUnsupported,
    input wire logic [15:0] vinMeasured,
    input wire logic [UNIT_W-1:0] unitCycles,
    input wire logic clearFaults,
    input wire logic statusClear,
    input wire logic outputOnCmd,
    output logic outputPermit,
    output logic ovFaultFlag,
    output logic [2:0] attemptCount
);
    logic [15:0] threshold;
    iovfr_pkg::iovfr_resp_s resp;
    iovfr_pkg::iovfr_state_e state;
    logic ovNow;
    logic onPrev;
    logic offOnSeen;
    logic clearEvent;
    logic timerStart;
    logic timerAbort;
    logic timerDone;
    logic timerBusy;
    logic failNow;
    logic moreTries;

    function automatic logic signed [47:0] linToFix(input logic [15:0] w);
        logic signed [47:0] m;
        logic [5:0] sh;
        m = {{37{w[10]}}, w[10:0]};
        sh = {w[15], w[15:11]} + `IOVFR_LIN_EXP_BIAS;
        linToFix = m <<< sh;
    endfunction : linToFix

    // ========================================================================
    // Command port.
    // ========================================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            threshold <= `IOVFR_THRESHOLD_RESET;
            resp <= `IOVFR_RESPONSE_RESET;
        end else if (cmd.valid && cmd.write) begin
            if (cmd.code == `IOVFR_CMD_THRESHOLD) begin
                threshold <= cmd.wdata; // [RL1]
            end else if (cmd.code == `IOVFR_CMD_RESPONSE) begin
                resp <= cmd.wdata[7:0]; // [RL2] [RL19]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
            cmdUnsupported <= 1'b0;
        end else begin
            rspValid <= cmd.valid && !cmd.write;
            cmdUnsupported <= cmd.valid && (cmd.code != `IOVFR_CMD_THRESHOLD) &&
                (cmd.code != `IOVFR_CMD_RESPONSE);
            if (cmd.valid && !cmd.write) begin
                case (cmd.code)
                    `IOVFR_CMD_THRESHOLD: rspData <= threshold; // [RL1]
                    `IOVFR_CMD_RESPONSE: rspData <= {8'h00, resp}; // [RL2]
                    default: rspData <= 16'h0000;
                endcase
            end
        end
    end

    // ========================================================================
    // Detection and status.
    // ========================================================================
    assign ovNow = linToFix(vinMeasured) > linToFix(threshold); // [RL18]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            onPrev <= 1'b1;
        end else begin
            onPrev <= outputOnCmd;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            offOnSeen <= 1'b0;
        end else if (outputOnCmd && !onPrev) begin
            offOnSeen <= 1'b1;
        end else begin
            offOnSeen <= 1'b0;
        end
    end

    assign clearEvent = clearFaults || statusClear || offOnSeen; // [RL6]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovFaultFlag <= 1'b0;
        end else if (ovNow) begin
            ovFaultFlag <= 1'b1; // [RL18]
        end else if (clearEvent) begin
            ovFaultFlag <= 1'b0;
        end
    end

    // ========================================================================
    // Response engine.
    // ========================================================================
    assign moreTries = (resp.retries == `IOVFR_RETRY_FOREVER) || // [RL16] [RL17]
        (({1'b0, attemptCount} + 4'h1) < {1'b0, resp.retries}); // [RL8] [RL9] [RL10]
    assign failNow = (state == iovfr_pkg::ST_RUN_ON) && timerDone && ovNow;

    always_comb begin
        timerStart = 1'b0;
        case (state)
            iovfr_pkg::ST_RUN: timerStart = ovNow && ((resp.action == `IOVFR_ACT_RUN_ON) ||
                ((resp.action == `IOVFR_ACT_DISABLE_RETRY) &&
                (resp.retries != `IOVFR_RETRY_NONE))); // [RL12]
            iovfr_pkg::ST_RUN_ON: timerStart = failNow && (resp.retries != `IOVFR_RETRY_NONE);
            iovfr_pkg::ST_OFF_WAIT: timerStart = timerDone && ovNow && moreTries; // [RL11]
            default: timerStart = 1'b0;
        endcase
    end
    assign timerAbort = !outputOnCmd;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= iovfr_pkg::ST_RUN;
        end else if (!outputOnCmd) begin
            state <= iovfr_pkg::ST_RUN; // [RL17]
        end else begin
            case (state)
                iovfr_pkg::ST_RUN: begin
                    if (ovNow) begin
                        case (resp.action)
                            `IOVFR_ACT_IGNORE: state <= iovfr_pkg::ST_RUN; // [RL3]
                            `IOVFR_ACT_RUN_ON: state <= iovfr_pkg::ST_RUN_ON; // [RL4]
                            `IOVFR_ACT_DISABLE_RETRY: begin
                                if (resp.retries == `IOVFR_RETRY_NONE) begin
                                    state <= iovfr_pkg::ST_LATCHED; // [RL7]
                                end else begin
                                    state <= iovfr_pkg::ST_OFF_WAIT; // [RL5]
                                end
                            end
                            default: state <= iovfr_pkg::ST_LATCHED; // [RL6]
                        endcase
                    end
                end
                iovfr_pkg::ST_RUN_ON: begin
                    if (timerDone && !ovNow) begin
                        state <= iovfr_pkg::ST_RUN;
                    end else if (failNow) begin
                        if (resp.retries == `IOVFR_RETRY_NONE) begin
                            state <= iovfr_pkg::ST_LATCHED; // [RL4]
                        end else begin
                            state <= iovfr_pkg::ST_OFF_WAIT; // [RL4]
                        end
                    end
                end
                iovfr_pkg::ST_OFF_WAIT: begin
                    if (timerDone) begin
                        if (!ovNow) begin
                            state <= iovfr_pkg::ST_RUN;
                        end else if (!moreTries) begin
                            state <= iovfr_pkg::ST_LATCHED; // [RL8] [RL9] [RL10] [RL16]
                        end
                    end
                end
                iovfr_pkg::ST_LATCHED: begin
                    if (clearEvent) begin
                        state <= iovfr_pkg::ST_RUN; // [RL6] [RL7]
                    end
                end
                default: state <= iovfr_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            attemptCount <= 3'h0;
        end else if (state == iovfr_pkg::ST_RUN) begin
            attemptCount <= 3'h0;
        end else if ((state == iovfr_pkg::ST_OFF_WAIT) && timerDone &&
            (attemptCount != 3'h7)) begin
            attemptCount <= attemptCount + 3'h1;
        end
    end

    assign outputPermit = (state == iovfr_pkg::ST_RUN) ||
        (state == iovfr_pkg::ST_RUN_ON); // [RL3] [RL5]

    iovfr_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(timerStart),
        .abort(timerAbort),
        .delayField(resp.delay),
        .unitCycles(unitCycles), // [RL14]
        .busy(timerBusy),
        .done(timerDone)
    );

    // ========================================================================
    // Checks.
    // ========================================================================
    property p_ignore;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN) && ovNow && outputOnCmd &&
            (resp.action == `IOVFR_ACT_IGNORE) |=> outputPermit [*2];
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault cut output"); // [RL3]

    property p_disable_now;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN) && ovNow && outputOnCmd && resp.action[1] |=>
            !outputPermit;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("output not disabled"); // [RL5]

    property p_latch_off;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN) && ovNow && outputOnCmd &&
            (resp.action == `IOVFR_ACT_LATCH_OFF) |=> (state == iovfr_pkg::ST_LATCHED);
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("not latched off"); // [RL6]

    property p_run_on;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN_ON) |-> (outputPermit && timerBusy) || timerDone;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run-on broken"); // [RL4]

    property p_no_retry;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN) && ovNow && outputOnCmd &&
            (resp.action == `IOVFR_ACT_DISABLE_RETRY) &&
            (resp.retries == `IOVFR_RETRY_NONE) |=> (state == iovfr_pkg::ST_LATCHED);
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("retry with zero setting"); // [RL7]

    property p_retry_cap;
        @(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_LATCHED) && ($past(state) == iovfr_pkg::ST_OFF_WAIT) |->
            (attemptCount == resp.retries);
    endproperty
    a_retry_cap: assert property (p_retry_cap) else $error("wrong attempt count"); // [RL10]

    property p_flag;
        @(posedge clk_sys) disable iff (rst)
        ovNow |=> ovFaultFlag;
    endproperty
    a_flag: assert property (p_flag) else $error("fault flag not set"); // [RL18]

    property p_write_thr;
        @(posedge clk_sys) disable iff (rst)
        cmd.valid && cmd.write && (cmd.code == `IOVFR_CMD_THRESHOLD) |=>
            (threshold == $past(cmd.wdata));
    endproperty
    a_write_thr: assert property (p_write_thr) else $error("threshold not written"); // [RL1]

    property p_read_resp;
        @(posedge clk_sys) disable iff (rst)
        cmd.valid && !cmd.write && (cmd.code == `IOVFR_CMD_RESPONSE) |=>
            rspValid && (rspData == {8'h00, $past(resp)});
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("response read wrong"); // [RL2]

    c_run_on: cover property (@(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_RUN_ON) ##1 (state == iovfr_pkg::ST_OFF_WAIT));
    c_recover: cover property (@(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_OFF_WAIT) ##1 (state == iovfr_pkg::ST_RUN));
    c_exhaust: cover property (@(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_OFF_WAIT) ##1 (state == iovfr_pkg::ST_LATCHED));
    c_clear: cover property (@(posedge clk_sys) disable iff (rst)
        (state == iovfr_pkg::ST_LATCHED) ##1 (state == iovfr_pkg::ST_RUN));
endmodule : iovfr_fault_response
`default_nettype wire

// *** common/iovfr_defines.svh ***
// Constants for the input over-voltage fault response block.
// Assumes inclusion by bare name.
`ifndef IOVFR_DEFINES_SVH
`define IOVFR_DEFINES_SVH
`define IOVFR_CMD_THRESHOLD 8'h55
`define IOVFR_CMD_RESPONSE 8'h56
`define IOVFR_THRESHOLD_RESET 16'h7BFF
`define IOVFR_RESPONSE_RESET 8'h80
`define IOVFR_ACT_IGNORE 2'h0
`define IOVFR_ACT_RUN_ON 2'h1
`define IOVFR_ACT_DISABLE_RETRY 2'h2
`define IOVFR_ACT_LATCH_OFF 2'h3
`define IOVFR_RETRY_NONE 3'h0
`define IOVFR_RETRY_FOREVER 3'h7
`define IOVFR_LIN_EXP_BIAS 6'h10
`endif

// *** common/iovfr_pkg.sv ***
// Types shared by the input over-voltage fault response block.
// Assumes nothing of its surroundings.
`default_nettype none
package iovfr_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_RUN_ON,
        ST_OFF_WAIT,
        ST_LATCHED
    } iovfr_state_e;

    typedef struct packed {
        logic [1:0] action;
        logic [2:0] retries;
        logic [2:0] delay;
    } iovfr_resp_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } iovfr_cmd_s;
endpackage : iovfr_pkg
`default_nettype wire

// *** rtl/iovfr_delay_timer.sv ***
// Delay timer: counts two to the power of the delay field, in time units.
// Assumes a unit length in clock cycles from the time-unit configuration.
`default_nettype none
module iovfr_delay_timer #(
    parameter int UNIT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] delayField,
    input wire logic [UNIT_W-1:0] unitCycles,
    output logic busy,
    output logic done
);
    logic [UNIT_W-1:0] cycleCnt;
    logic [7:0] unitCnt;
    logic [7:0] unitTarget;
    logic [UNIT_W-1:0] unitLast;
    logic lastCycle;

    // ========================================================================
    // Delay decode and counting.
    // ========================================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unitTarget <= 8'h00;
        end else if (start) begin
            unitTarget <= 8'(9'h001 << delayField) - 8'h01; // [RL13] [RL15]
        end
    end

    assign unitLast = (unitCycles == '0) ? '0 : unitCycles - 1'b1;
    assign lastCycle = busy && (cycleCnt == unitLast) && (unitCnt == unitTarget);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cycleCnt <= '0;
            unitCnt <= 8'h00;
        end else if (start) begin
            busy <= 1'b1;
            cycleCnt <= '0;
            unitCnt <= 8'h00;
        end else if (abort || lastCycle) begin
            busy <= 1'b0;
        end else if (busy) begin
            if (cycleCnt == unitLast) begin
                cycleCnt <= '0;
                unitCnt <= unitCnt + 8'h01; // [RL11]
            end else begin
                cycleCnt <= cycleCnt + 1'b1;
            end
        end
    end

    assign done = lastCycle && !abort; // [RL11]

    // ========================================================================
    // Checks.
    // ========================================================================
    logic [23:0] spanCnt;
    logic [2:0] spanField;
    logic [UNIT_W-1:0] spanUnit;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            spanCnt <= 24'h000000;
            spanField <= 3'h0;
            spanUnit <= '0;
        end else if (start) begin
            spanCnt <= 24'h000001;
            spanField <= delayField;
            spanUnit <= unitCycles;
        end else if (spanCnt != 24'hFFFFFF) begin
            spanCnt <= spanCnt + 24'h000001;
        end
    end

    property p_span;
        @(posedge clk_sys) disable iff (rst)
        done && (spanUnit != '0) |->
            spanCnt == 24'(32'(spanUnit) << spanField);
    endproperty
    a_span: assert property (p_span) else $error("delay span wrong"); // [RL13]

    property p_restart_clears;
        @(posedge clk_sys) disable iff (rst)
        done && !start |=> !done;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("done held over"); // [RL11]
endmodule : iovfr_delay_timer
`default_nettype wire

// *** tb/iovfr_host_model.sv ***
// Host model that issues threshold and response commands to the block.
// Assumes the caller enters each task just after a rising clock edge.
`default_nettype none
module iovfr_host_model (
    input wire logic clk_sys,
    output var iovfr_pkg::iovfr_cmd_s cmd,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic cmdUnsupported
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Command issue
    initial begin
        cmd = '0;
    end
    // Holds one command through its taking edge, then scrambles the fields.
    task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
        cmd.valid = 1'b1;
        cmd.write = wr;
        cmd.code = code;
        cmd.wdata = data;
        @(posedge clk_sys);
        #1;
        cmd.valid = 1'b0;
        cmd.write = ~wr;
        cmd.code = ~code;
        cmd.wdata = ~data;
    endtask : issue
    // Word writes for the threshold, byte in the low half for the response.
    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        issue(1'b1, code, data);
        @(posedge clk_sys);
        #1;
    endtask : write_reg
    // Reads with a bounded wait for the answer pulse.
    task automatic read_reg(input logic [7:0] code, output logic [15:0] data,
                            output logic got, output logic unsup);
        int n;
        got = 1'b0;
        unsup = 1'b0;
        data = 'x;
        issue(1'b0, code, 16'h0000);
        for (n = 0; n < 3 && !got; n++) begin
            if (cmdUnsupported === 1'b1) unsup = 1'b1;
            if (rspValid === 1'b1) begin
                got = 1'b1;
                data = rspData;
            end else begin
                @(posedge clk_sys);
                #1;
            end
        end
        @(posedge clk_sys);
        #1;
    endtask : read_reg
endmodule : iovfr_host_model
`default_nettype wire

// *** tb/iovfr_fault_response_tb.sv ***
// Self-checking bench for the input over-voltage fault response block.
// Assumes the design, package and defines header are compiled alongside.
`default_nettype none
`include "iovfr_defines.svh"
module iovfr_fault_response_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clearFaults = 1'b0;
    logic statusClear = 1'b0;
    logic outputOnCmd = 1'b1;
    logic [15:0] vinMeasured = 16'h0000;
    logic [15:0] unitCycles = 16'h0002;
    iovfr_pkg::iovfr_cmd_s cmd;
    logic rspValid, cmdUnsupported, outputPermit, ovFaultFlag;
    logic [15:0] rspData;
    logic [2:0] attemptCount;
    int err_count = 0;
    int checks_done = 0;
    // ==========================================================
    // Clock, instances and watchdog
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    iovfr_fault_response #(.UNIT_W(16)) uut (.clk_sys(clk_sys), .rst(rst), .cmd(cmd),
        .rspValid(rspValid), .rspData(rspData), .cmdUnsupported(cmdUnsupported),
        .vinMeasured(vinMeasured), .unitCycles(unitCycles), .clearFaults(clearFaults),
        .statusClear(statusClear), .outputOnCmd(outputOnCmd), .outputPermit(outputPermit),
        .ovFaultFlag(ovFaultFlag), .attemptCount(attemptCount));
    iovfr_host_model host (.clk_sys(clk_sys), .cmd(cmd), .rspValid(rspValid),
        .rspData(rspData), .cmdUnsupported(cmdUnsupported));
    initial begin
        #(100 * 20000);
        err_count++;
        finish_test();
    end
    // ==========================================================
    // Helper tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic set_resp(input logic [1:0] act, input logic [2:0] ret, input logic [2:0] dly);
        iovfr_pkg::iovfr_resp_s rs;
        rs.action = act;
        rs.retries = ret;
        rs.delay = dly;
        host.write_reg(`IOVFR_CMD_RESPONSE, {8'h00, rs});
    endtask : set_resp
    task automatic recover();
        vinMeasured = 16'h0063;
        tick(1);
        clearFaults = 1'b1;
        tick(1);
        clearFaults = 1'b0;
        tick(2);
    endtask : recover
    // Counts cycles until the output gate reaches a level, giving up after a bound.
    task automatic wait_permit(input logic val, output int n);
        n = 0;
        while (outputPermit !== val && n < 600) begin
            tick(1);
            n++;
        end
    endtask : wait_permit
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // Test sequence
    initial begin
        logic [15:0] d;
        logic g, u;
        int n, r, dl;
        tick(4);
        rst = 1'b0;
        check("permit at reset", outputPermit, 1);
        host.read_reg(`IOVFR_CMD_THRESHOLD, d, g, u);
        check("threshold reset", d, 16'h7BFF);
        host.read_reg(`IOVFR_CMD_RESPONSE, d, g, u);
        check("response reset", d, 16'h0080);
        host.write_reg(`IOVFR_CMD_THRESHOLD, 16'h0064);
        host.write_reg(`IOVFR_CMD_RESPONSE, 16'hFFA5);
        host.write_reg(8'h57, 16'h1234);
        host.read_reg(`IOVFR_CMD_THRESHOLD, d, g, u);
        check("threshold readback", d, 16'h0064);
        host.read_reg(`IOVFR_CMD_RESPONSE, d, g, u);
        check("response readback", d, 16'h00A5);
        host.read_reg(8'h57, d, g, u);
        check("unmapped data", d, 16'h0000);
        check("unmapped flag", u, 1);
        // Ignore action, with the strict threshold boundary first.
        set_resp(2'h0, 3'h0, 3'h0);
        vinMeasured = 16'h0064;
        tick(5);
        check("flag at threshold", ovFaultFlag, 0);
        vinMeasured = 16'h0065;
        tick(2);
        check("flag above threshold", ovFaultFlag, 1);
        for (n = 0; n < 20; n++) begin
            tick(1);
            check("ignore permit", outputPermit, 1);
        end
        recover();
        check("flag cleared", ovFaultFlag, 0);
        // Disable and retry for every finite retry count.
        for (r = 0; r < 7; r++) begin
            set_resp(2'h2, r[2:0], 3'h0);
            vinMeasured = 16'h0065;
            tick(2);
            check("disable permit", outputPermit, 0);
            tick((r + 1) * 4 + 10);
            check("attempts made", attemptCount, r[2:0]);
            vinMeasured = 16'h0063;
            tick(10);
            check("stays off", outputPermit, 0);
            recover();
            check("on after clear", outputPermit, 1);
        end
        // Attempt spacing for several delay codes with a three-cycle unit.
        unitCycles = 16'h0003;
        for (dl = 0; dl < 4; dl++) begin
            set_resp(2'h2, 3'h2, dl[2:0]);
            vinMeasured = 16'h0065;
            wait_permit(1'b0, n);
            n = 0;
            while (attemptCount === 3'h0 && n < 600) begin
                tick(1);
                n++;
            end
            check("first attempt", n, 3 * (1 << dl));
            n = 0;
            while (attemptCount === 3'h1 && n < 600) begin
                tick(1);
                n++;
            end
            check("attempt spacing", n, 3 * (1 << dl));
            recover();
        end
        unitCycles = 16'h0002;
        // Endless retry recovers once the input falls.
        set_resp(2'h2, 3'h7, 3'h0);
        vinMeasured = 16'h0065;
        tick(40);
        check("endless off", outputPermit, 0);
        vinMeasured = 16'h0063;
        wait_permit(1'b1, n);
        check("endless back on", n < 6, 1);
        check("sticky flag", ovFaultFlag, 1);
        recover();
        // Run-on: span 8 cycles, fault persists, then one retry and latch.
        set_resp(2'h1, 3'h1, 3'h2);
        vinMeasured = 16'h0065;
        tick(2);
        tick(6);
        check("run-on permit", outputPermit, 1);
        wait_permit(1'b0, n);
        check("run-on expiry", n < 5, 1);
        tick(20);
        check("run-on attempts", attemptCount, 1);
        recover();
        // Run-on with the fault gone before expiry keeps the output.
        set_resp(2'h1, 3'h1, 3'h2);
        vinMeasured = 16'h0065;
        tick(3);
        vinMeasured = 16'h0063;
        tick(15);
        check("run-on cleared", outputPermit, 1);
        recover();
        // Latch off, then clear by status bit and by off-then-on.
        set_resp(2'h3, 3'h1, 3'h0);
        vinMeasured = 16'h0065;
        tick(3);
        vinMeasured = 16'h0063;
        tick(20);
        check("latched off", outputPermit, 0);
        statusClear = 1'b1;
        tick(1);
        statusClear = 1'b0;
        tick(3);
        check("status clear on", outputPermit, 1);
        vinMeasured = 16'h0065;
        tick(3);
        vinMeasured = 16'h0063;
        tick(5);
        check("latched again", outputPermit, 0);
        outputOnCmd = 1'b0;
        tick(1);
        outputOnCmd = 1'b1;
        tick(4);
        check("off-on clear", outputPermit, 1);
        finish_test();
    end
endmodule : iovfr_fault_response_tb
`default_nettype wire
